// >>> dv/dual_clock_fifo_with_flags_tb_top.sv
module dual_clock_fifo_with_flags_tb_top import fifo_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        full_clear_reset_n = 1'b1;
    logic        pointer_only_reset_n = 1'b1;
    logic        out_en_n = 1'b0;
    logic        wr_clk, rd_clk, wr_en_n, rd_en_n, serial_load_en_n;
    logic        offset_access_n, read_rewind_n, mode_strap_serial_in, rd_data_oe_n;
    logic [17:0] wr_data, rd_data;
    flags_s      flags;
    int          n_mismatch = 0;
    int          n_compared = 0;
    logic [17:0] words [3] = '{18'h2AAAA, 18'h15555, 18'h3FFFF};
    always #2.5 ref_clk = ~ref_clk;
    fifo_far_side i_fifo_far_side (.ref_clk(ref_clk), .wr_clk(wr_clk), .rd_clk(rd_clk),
        .wr_en_n(wr_en_n), .rd_en_n(rd_en_n), .serial_load_en_n(serial_load_en_n),
        .offset_access_n(offset_access_n), .read_rewind_n(read_rewind_n),
        .mode_strap_serial_in(mode_strap_serial_in), .wr_data(wr_data));
    dual_clock_fifo_with_flags i_dual_clock_fifo_with_flags (.ref_clk(ref_clk), .rst_n(rst_n),
        .wr_clk(wr_clk), .rd_clk(rd_clk), .full_clear_reset_n(full_clear_reset_n),
        .pointer_only_reset_n(pointer_only_reset_n), .read_rewind_n(read_rewind_n),
        .mode_strap_serial_in(mode_strap_serial_in), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n),
        .serial_load_en_n(serial_load_en_n), .offset_access_n(offset_access_n),
        .out_en_n(out_en_n), .unused_strap(1'b0), .wr_data(wr_data), .rd_data(rd_data),
        .rd_data_oe_n(rd_data_oe_n), .flags(flags));
    task automatic chk(input logic [17:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic ld_n, input logic [17:0] d);
        i_fifo_far_side.wr_cycle(1'b0, 1'b1, 1'b0, ld_n, d);
    endtask
    task automatic rd(input logic ld_n, input logic [17:0] exp);
        i_fifo_far_side.rd_cycle(1'b0, ld_n, 1'b1);
        chk(rd_data, exp);
    endtask
    // Flags are clock-domain registered, so let both sides tick before looking
    task automatic idle;
        i_fifo_far_side.rd_cycle(1'b1, 1'b1, 1'b1);
        i_fifo_far_side.rd_cycle(1'b1, 1'b1, 1'b1);
        i_fifo_far_side.wr_cycle(1'b1, 1'b1, 1'b0, 1'b1, 18'h00000);
    endtask
    task automatic hold_low(input bit full);
        if (full) full_clear_reset_n <= 1'b0;
        else pointer_only_reset_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        full_clear_reset_n <= 1'b1;
        pointer_only_reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        i_fifo_far_side.strap(1'b0, 1'b0);
        hold_low(1'b1);
        chk({17'h0, rd_data_oe_n}, 18'h00000);
        chk({13'h0, flags}, 18'h00015);
        rd(1'b0, 18'h0007F);
        rd(1'b0, 18'h0007F);
        wr(1'b0, 18'h00002);
        wr(1'b0, 18'h00005);
        rd(1'b0, 18'h00002);
        rd(1'b0, 18'h00005);
        foreach (words[i]) begin
            wr(1'b1, words[i]);
            idle();
            chk({13'h0, flags}, i == 0 ? 18'h0001D : 18'h0001F);
        end
        foreach (words[i]) rd(1'b1, words[i]);
        idle();
        chk({13'h0, flags}, 18'h00015);
        rd(1'b1, 18'h3FFFF);
        i_fifo_far_side.rd_cycle(1'b1, 1'b1, 1'b0);
        rd(1'b1, 18'h2AAAA);
        rd(1'b1, 18'h15555);
        hold_low(1'b0);
        chk(rd_data, 18'h00000);
        idle();
        chk({13'h0, flags}, 18'h00015);
        rd(1'b1, 18'h00000);
        rd(1'b0, 18'h00002);
        rd(1'b0, 18'h00005);
        i_fifo_far_side.strap(1'b1, 1'b1);
        hold_low(1'b1);
        chk({13'h0, flags}, 18'h0000D);
        rd(1'b0, 18'h003FF);
        rd(1'b0, 18'h003FF);
        for (int i = 29; i >= 0; i--) begin
            i_fifo_far_side.wr_cycle(1'b1, 1'b0, 30'h00048003 >> i, 1'b0, 18'h0);
        end
        rd(1'b0, 18'h00003);
        rd(1'b0, 18'h00009);
        wr(1'b1, 18'h12345);
        repeat (3) i_fifo_far_side.rd_cycle(1'b1, 1'b1, 1'b1);
        chk(rd_data, 18'h12345);
        chk({17'h0, flags.empty_or_out_valid}, 18'h00000);
        wr(1'b1, 18'h0ABCD);
        idle();
        chk(rd_data, 18'h12345);
        rd(1'b1, 18'h0ABCD);
        out_en_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({17'h0, rd_data_oe_n}, 18'h00001);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end
endmodule

// >>> dv/fifo_far_side.sv
module fifo_far_side (
    input  wire logic   ref_clk,
    output logic        wr_clk = 1'b0,
    output logic        rd_clk = 1'b0,
    output logic        wr_en_n = 1'b1,
    output logic        rd_en_n = 1'b1,
    output logic        serial_load_en_n = 1'b1,
    output logic        offset_access_n = 1'b1,
    output logic        read_rewind_n = 1'b1,
    output logic        mode_strap_serial_in = 1'b0,
    output logic [17:0] wr_data = 18'h00000
);
    timeunit 1ns;
    timeprecision 100ps;
    // Each phase spans 4 system cycles so the pin sampler never misses an edge
    task automatic pulse(input bit wr);
        repeat (4) @(posedge ref_clk);
        if (wr) wr_clk <= 1'b1;
        else rd_clk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr_clk <= 1'b0;
        rd_clk <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic strap(input logic m, ld);
        @(posedge ref_clk);
        mode_strap_serial_in <= m;
        offset_access_n <= ld;
    endtask
    task automatic wr_cycle(input logic we_n, se_n, si, ld_n, input logic [17:0] d);
        @(posedge ref_clk);
        wr_en_n <= we_n;
        serial_load_en_n <= se_n;
        mode_strap_serial_in <= si;
        offset_access_n <= ld_n;
        wr_data <= d;
        pulse(1'b1);
        wr_en_n <= 1'b1;
        serial_load_en_n <= 1'b1;
        offset_access_n <= 1'b1;
        wr_data <= ~d; // Released lines must not look like the last word
        mode_strap_serial_in <= ~si;
    endtask
    task automatic rd_cycle(input logic re_n, ld_n, rt_n);
        @(posedge ref_clk);
        rd_en_n <= re_n;
        offset_access_n <= ld_n;
        read_rewind_n <= rt_n;
        pulse(1'b0);
        rd_en_n <= 1'b1;
        offset_access_n <= 1'b1;
        read_rewind_n <= 1'b1;
    endtask
endmodule

// >>> dv/fifo_flag_checker_asserts.sv
module fifo_flag_checker
    import fifo_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        rd_clk,
    input wire logic        full_clear_reset_n,
    input wire logic        pointer_only_reset_n,
    input wire logic        mode_strap_serial_in,
    input wire logic        out_en_n,
    input wire logic [17:0] rd_data,
    input wire logic        rd_data_oe_n,
    input wire flags_s      flags
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       rd_q;
    logic [3:0] rd_age;
    logic [3:0] rst_age;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Ages since the last read edge and the last reset, saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q    <= 1'b0;
            rd_age  <= 4'hF;
            rst_age <= 4'h0;
        end else begin
            rd_q    <= rd_clk;
            rd_age  <= (rd_clk && !rd_q) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hF};
            rst_age <= (!full_clear_reset_n || !pointer_only_reset_n) ? 4'h0
                       : rst_age + {3'h0, rst_age != 4'hF};
        end
    end
    chk_oe_drive: assert property (!out_en_n [*5] |-> !rd_data_oe_n)
        else $error("data bus not driven");
    chk_oe_float: assert property (out_en_n [*5] |-> rd_data_oe_n)
        else $error("data bus not released");
    chk_clear_out: assert property (!full_clear_reset_n [*6] |-> rd_data == 18'h00000)
        else $error("output word not cleared");
    chk_clear_levels: assert property (!full_clear_reset_n [*6] |->
        !flags.near_empty_n && flags.near_full_n && flags.half_level_n)
        else $error("level flags wrong in clear");
    chk_std_flags: assert property ((!full_clear_reset_n && !mode_strap_serial_in) [*6]
        |-> !flags.empty_or_out_valid && flags.full_or_space_ok)
        else $error("standard flags wrong in clear");
    chk_ft_flags: assert property ((!full_clear_reset_n && mode_strap_serial_in) [*6]
        |-> flags.empty_or_out_valid)
        else $error("fall-through ready wrong in clear");
    chk_part_clear: assert property (!pointer_only_reset_n [*6] |->
        rd_data == 18'h00000 && flags.half_level_n)
        else $error("partial reset left data");
    chk_rd_steady: assert property ($changed(rd_data) |-> rd_age < 4'h8 || rst_age < 4'h8)
        else $error("read word moved without read edge");
endmodule

bind dual_clock_fifo_with_flags fifo_flag_checker i_fifo_flag_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .rd_clk(rd_clk), .full_clear_reset_n(full_clear_reset_n),
    .pointer_only_reset_n(pointer_only_reset_n), .mode_strap_serial_in(mode_strap_serial_in),
    .out_en_n(out_en_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n), .flags(flags));

// >>> rtl/dual_clock_fifo_with_flags.sv
// The implementer's own choices: the plain strobed port.
`include "fifo_defines.svh"

module dual_clock_fifo_with_flags
    import fifo_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                wr_clk,
    input  wire logic                rd_clk,
    input  wire logic                full_clear_reset_n,
    input  wire logic                pointer_only_reset_n,
    input  wire logic                read_rewind_n,
    input  wire logic                mode_strap_serial_in,
    input  wire logic                wr_en_n,
    input  wire logic                rd_en_n,
    input  wire logic                serial_load_en_n,
    input  wire logic                offset_access_n,
    input  wire logic                out_en_n,
    input  wire logic                unused_strap,
    input  wire logic [`DATA_W-1:0]  wr_data,
    output logic      [`DATA_W-1:0]  rd_data,
    output logic                     rd_data_oe_n,
    output flags_s                   flags
);

    // Every pin crosses into ref_clk through two flops before use
    // Clock pins reset to their idle low level so no false edge follows reset
    logic [`SYNC_W-1:0] sync1_reg;
    logic [`SYNC_W-1:0] sync2_reg;
    logic               wclk_d_reg;
    logic               rclk_d_reg;

    wire [`SYNC_W-1:0] pins = {wr_clk, rd_clk, full_clear_reset_n, pointer_only_reset_n,
                               read_rewind_n, mode_strap_serial_in, wr_en_n, rd_en_n,
                               serial_load_en_n, offset_access_n, out_en_n, wr_data};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg  <= `SYNC_INIT;
            sync2_reg  <= `SYNC_INIT;
            wclk_d_reg <= 1'b0;
            rclk_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= pins;
            sync2_reg  <= sync1_reg;
            wclk_d_reg <= sync2_reg[28];
            rclk_d_reg <= sync2_reg[27];
        end
    end

    wire               wclk_s   = sync2_reg[28];
    wire               rclk_s   = sync2_reg[27];
    wire               fcr_s    = ~sync2_reg[26];
    wire               pcr_s    = ~sync2_reg[25];
    wire               rewind_s = ~sync2_reg[24];
    wire               strap_si = sync2_reg[23];
    wire               wen_s    = ~sync2_reg[22];
    wire               ren_s    = ~sync2_reg[21];
    wire               sen_s    = ~sync2_reg[20];
    wire               ld_raw   = sync2_reg[19];
    wire               ld_s     = ~sync2_reg[19];
    wire               oe_s     = ~sync2_reg[18];
    wire [`DATA_W-1:0] din_s    = sync2_reg[`DATA_W-1:0];

    wire wr_edge = wclk_s & ~wclk_d_reg;
    wire rd_edge = rclk_s & ~rclk_d_reg;
    wire any_rst = fcr_s | pcr_s;

    // Settings and offsets
    mode_e             mode_reg;
    logic              serial_mode_reg;
    logic [`OFF_W-1:0] empty_off_reg;
    logic [`OFF_W-1:0] full_off_reg;
    logic              wsel_reg;
    logic              rsel_reg;

    wire [`OFF_W-1:0] def_off   = ld_raw ? `OFF_DEF_LONG : `OFF_DEF_SHORT;
    wire              par_load  = wr_edge & wen_s & ld_s & ~serial_mode_reg;
    wire              ser_load  = wr_edge & sen_s & ld_s & serial_mode_reg;
    wire [`OFF_W-1:0] par_word  = din_s[`OFF_W-1:0];
    // The top bit of the full offset falls off the chain end
    wire [2*`OFF_W-1:0] ser_shift = {full_off_reg[`OFF_W-2:0], empty_off_reg, strap_si};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg        <= MODE_STANDARD;
            serial_mode_reg <= 1'b0;
            empty_off_reg   <= `OFF_DEF_SHORT;
            full_off_reg    <= `OFF_DEF_SHORT;
            wsel_reg        <= 1'b0;
        end else if (fcr_s) begin
            mode_reg        <= strap_si ? MODE_FALL_THROUGH : MODE_STANDARD;
            serial_mode_reg <= ld_raw;
            empty_off_reg   <= def_off;
            full_off_reg    <= def_off;
            wsel_reg        <= 1'b0;
        end else if (pcr_s) begin
            wsel_reg        <= 1'b0;
        end else if (par_load) begin
            if (wsel_reg) begin
                full_off_reg  <= par_word;
            end else begin
                empty_off_reg <= par_word;
            end
            wsel_reg <= ~wsel_reg;
        end else if (ser_load) begin
            // Serial bits enter at the empty offset bottom and carry into the full offset
            {full_off_reg, empty_off_reg} <= ser_shift;
        end
    end

    // Queue storage, flops without reset to keep the array cheap
    logic [`DATA_W-1:0] mem [`DEPTH];
    logic [`PTR_W-1:0]  wr_ptr_reg;
    logic [`PTR_W-1:0]  rd_ptr_reg;

    wire [`PTR_W-1:0] count   = wr_ptr_reg - rd_ptr_reg;
    wire              is_full = (count == `FULL_LEVEL);
    wire              is_empty = (count == '0);
    wire              do_write = wr_edge & wen_s & ~ld_s & ~is_full & ~any_rst;

    always_ff @(posedge ref_clk) begin
        if (do_write) begin
            mem[wr_ptr_reg[`ADDR_W-1:0]] <= din_s;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
        end else if (any_rst) begin
            wr_ptr_reg <= '0;
        end else if (do_write) begin
            wr_ptr_reg <= wr_ptr_reg + 16'h0001;
        end
    end

    // Read side
    logic               out_valid_reg;
    logic [1:0]         avail_dly_reg;
    logic               eflag_reg;
    logic               near_empty_reg;
    logic [`DATA_W-1:0] rd_data_reg;

    wire ft       = (mode_reg == MODE_FALL_THROUGH);
    wire off_read = rd_edge & ren_s & ld_s;
    wire std_pop  = rd_edge & ren_s & ~ld_s & ~ft & ~is_empty & ~rewind_s;
    // Fall-through loads when the holding slot is free or being consumed
    wire ft_take  = ~out_valid_reg | (ren_s & ~ld_s);
    wire ft_pop   = rd_edge & ft & ~rewind_s & ft_take & ~is_empty & avail_dly_reg[1];
    wire pop      = std_pop | ft_pop;
    wire [`DATA_W-1:0] off_word = {3'h0, rsel_reg ? full_off_reg : empty_off_reg};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_reg    <= '0;
            rd_data_reg   <= '0;
            out_valid_reg <= 1'b0;
            avail_dly_reg <= 2'h0;
            rsel_reg      <= 1'b0;
        end else if (any_rst) begin
            rd_ptr_reg    <= '0;
            rd_data_reg   <= '0;
            out_valid_reg <= 1'b0;
            avail_dly_reg <= 2'h0;
            rsel_reg      <= 1'b0;
        end else if (rd_edge) begin
            avail_dly_reg <= {avail_dly_reg[0], ~is_empty};
            if (rewind_s) begin
                rd_ptr_reg    <= '0;
                out_valid_reg <= 1'b0;
                avail_dly_reg <= 2'h0;
            end else if (off_read) begin
                rd_data_reg <= off_word;
                rsel_reg    <= ~rsel_reg;
            end else if (pop) begin
                rd_data_reg   <= mem[rd_ptr_reg[`ADDR_W-1:0]];
                rd_ptr_reg    <= rd_ptr_reg + 16'h0001;
                out_valid_reg <= 1'b1;
            end else if (ft & ren_s) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

    // Flag registers, full flags on the write edge, half level every cycle
    logic fflag_reg;
    logic near_full_reg;
    logic half_reg;

    wire [`PTR_W-1:0] pop_count = count - {15'h0000, pop};
    wire [`PTR_W-1:0] full_thr  = `FULL_LEVEL - {1'b0, full_off_reg};

    // Half level follows either side, so it is refreshed every cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_reg <= 1'b1;
        end else begin
            half_reg <= ~(count > `HALF_LEVEL);
        end
    end

    // Write side flags move only on write edges and on either reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fflag_reg     <= 1'b1;
            near_full_reg <= 1'b1;
        end else if (any_rst) begin
            fflag_reg     <= 1'b1;
            near_full_reg <= 1'b1;
        end else if (wr_edge) begin
            fflag_reg     <= ~is_full;
            near_full_reg <= ~(count > full_thr);
        end
    end

    // Read side flags move only on read edges and on either reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eflag_reg      <= 1'b0;
            near_empty_reg <= 1'b0;
        end else if (any_rst) begin
            eflag_reg      <= 1'b0;
            near_empty_reg <= 1'b0;
        end else if (rd_edge) begin
            // Rewind forces empty for one read edge before the count is trusted again
            eflag_reg      <= rewind_s ? 1'b0 : (pop_count != '0);
            near_empty_reg <= ~(pop_count < {1'b0, empty_off_reg});
        end
    end

    // Fall-through space output is low while room remains, so it inverts the full flag
    assign flags.full_or_space_ok   = ft ? ~fflag_reg : fflag_reg;
    assign flags.empty_or_out_valid = ft ? ~out_valid_reg : eflag_reg;
    assign flags.near_full_n        = near_full_reg;
    assign flags.near_empty_n       = near_empty_reg;
    assign flags.half_level_n       = half_reg;
    assign rd_data                  = rd_data_reg;
    assign rd_data_oe_n             = ~oe_s;

endmodule

// >>> rtl/fifo_defines.svh
`ifndef FIFO_DEFINES_SVH
`define FIFO_DEFINES_SVH

`define DATA_W        18
`define DEPTH         32768
`define ADDR_W        15
`define PTR_W         16
`define OFF_W         15
`define OFF_DEF_SHORT 15'h007F
`define OFF_DEF_LONG  15'h03FF
`define HALF_LEVEL    16'h4000
`define FULL_LEVEL    16'h8000
`define SYNC_W        29
`define SYNC_INIT     29'h07FC0000

`endif

// >>> rtl/fifo_pkg.sv
package fifo_pkg;
    typedef enum logic {MODE_STANDARD, MODE_FALL_THROUGH} mode_e;

    typedef struct packed {
        logic full_or_space_ok;
        logic empty_or_out_valid;
        logic near_full_n;
        logic near_empty_n;
        logic half_level_n;
    } flags_s;
endpackage
